/* verilog/pwpc_pkg.sv */
// package: register map, field layouts and timing constants of the pulse width/period counter
package pwpc_pkg;
	// register byte offsets
	localparam logic [7:0] PWPC_CTRL_OFS = 8'h00;
	localparam logic [7:0] PWPC_CMD_OFS = 8'h04;
	localparam logic [7:0] PWPC_TBASE_OFS = 8'h08;
	localparam logic [7:0] PWPC_LIMIT_OFS = 8'h0C;
	localparam logic [7:0] PWPC_COUNT_OFS = 8'h10;
	localparam logic [7:0] PWPC_TIME_OFS = 8'h14;
	localparam logic [7:0] PWPC_STAT_OFS = 8'h18;
	localparam logic [7:0] PWPC_ISTAT_OFS = 8'h1C;
	localparam logic [7:0] PWPC_ICLR_OFS = 8'h20;
	localparam logic [7:0] PWPC_IEN_OFS = 8'h24;
	localparam logic [7:0] PWPC_PGEN_OFS = 8'h28;
	// measurement type codes
	localparam logic [1:0] PWPC_MT_HIGH = 2'h0;
	localparam logic [1:0] PWPC_MT_LOW = 2'h1;
	localparam logic [1:0] PWPC_MT_PER_RISE = 2'h2;
	localparam logic [1:0] PWPC_MT_PER_FALL = 2'h3;
	// field positions
	localparam int PWPC_CMD_START_BIT = 0;
	localparam int PWPC_CMD_ABORT_BIT = 1;
	localparam int PWPC_IRQ_DONE_BIT = 0;
	localparam int PWPC_IRQ_OVF_BIT = 1;
	localparam int PWPC_IRQ_TMO_BIT = 2;
	// reset values
	localparam logic [31:0] PWPC_TBASE_RST = 32'h0000_0000;
	localparam logic [31:0] PWPC_LIMIT_RST = 32'hFFFF_FFFF;
	localparam logic [15:0] PWPC_PGEN_RST = 16'h0001;
	// timebase and timing
	localparam int PWPC_CLK_HZ = 50_000_000;
	localparam logic [31:0] PWPC_INT_TB_HZ = 32'd10_000_000;
	localparam logic [31:0] PWPC_LIMIT_DEFAULT = 32'hFFFF_FFFF;
	localparam int PWPC_TB_DIV = PWPC_CLK_HZ / 10_000_000;
	localparam int PWPC_US_DIV = PWPC_CLK_HZ / 1_000_000;
	localparam int PWPC_DEF_LIMIT_S = 5;
	localparam int PWPC_DEF_LIMIT_US = PWPC_DEF_LIMIT_S * 1_000_000;
	localparam logic [18:0] PWPC_RANGE_TICKS = 19'd262144;
	localparam logic [31:0] PWPC_UDF_THRESH = 32'd4;
	localparam logic [31:0] PWPC_TC_SINGLE = 32'h0000_FFFF;
	localparam logic [31:0] PWPC_TC_CASCADE = 32'hFFFF_FFFF;
	localparam logic [19:0] PWPC_US_PER_S = 20'd1_000_000;
	localparam int PWPC_DIV_STEPS = 64;
	// control register layout
	typedef struct packed {
		logic pgen_en;
		logic cascade;
		logic [1:0] mtype;
	} pwpc_ctrl_t;
	localparam pwpc_ctrl_t PWPC_CTRL_RST = '{pgen_en: 1'b0, cascade: 1'b0, mtype: PWPC_MT_PER_RISE};
	// measurement result flags
	typedef struct packed {
		logic timeout;
		logic underflow;
		logic overflow;
		logic valid;
	} pwpc_res_t;
	typedef enum logic [2:0] {PWPC_IDLE, PWPC_ARM, PWPC_COUNT, PWPC_DIVIDE} pwpc_state_t;
endpackage

/* verilog/pwpc_counter.sv */
// module: pulse width/period counter with apb registers, timeout and pulse-train output
// Function
// - type 0 high phase, 1 low phase
// - type 2 rising period default, 3 falling
// - count timebase ticks while input gates interval
// - timebase 0 or 10000000 selects internal clock
// - time result equals count over timebase, flagged
// - valid only without overflow or underflow
// - overflow at terminal count, not an error
// - cascaded count is high shl 16 plus low
// - limit of -1 selects default limit
// - timeout when no reading within limit
// - continuous mode toggles output pulse train
`timescale 1ns/1ps
`default_nettype none
module pwpc_counter
	import pwpc_pkg::*;
#(
	parameter int DEF_LIMIT_US = PWPC_DEF_LIMIT_US
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic measured_input_pin,
	input wire logic ext_timebase_pin,
	output logic counter_output_pin,
	output logic irq
);
	// opening edge of the selected interval
	function automatic logic open_edge(input logic [1:0] mt, input logic rise, input logic fall);
		open_edge = (mt == PWPC_MT_HIGH || mt == PWPC_MT_PER_RISE) ? rise : fall;
	endfunction
	// closing edge of the selected interval
	function automatic logic close_edge(input logic [1:0] mt, input logic rise, input logic fall);
		close_edge = (mt == PWPC_MT_LOW || mt == PWPC_MT_PER_RISE) ? rise : fall;
	endfunction

	pwpc_ctrl_t ctrl_q; // mode, cascade, pulse-train enable
	logic [31:0] tbase_q; // timebase setting in hz
	logic [31:0] limit_q; // time limit in microseconds, all ones = default
	logic [15:0] pgen_q; // pulse-train half period in timebase ticks
	logic [2:0] ien_q; // interrupt enables
	logic [2:0] istat_q; // sticky interrupt status
	pwpc_res_t res_q; // flags of the last measurement
	pwpc_state_t state_q; // measurement sequencer
	logic [31:0] cnt_q; // accumulated timebase ticks
	logic [31:0] time_q; // reported time in microseconds
	logic [2:0] gate_sync_q; // three-stage synchroniser on the measured pin
	logic gate_lvl_q; // filtered level of the measured pin
	logic [2:0] etb_sync_q; // three-stage synchroniser on the external timebase
	logic etb_lvl_q; // filtered level of the external timebase
	logic [2:0] tb_div_q; // internal timebase prescaler
	logic [5:0] us_div_q; // microsecond prescaler
	logic [31:0] us_cnt_q; // microseconds since start
	logic [18:0] rng_cnt_q; // timebase ticks since start, saturating
	logic [63:0] rem_q; // divider remainder
	logic [63:0] quo_q; // divider dividend / quotient
	logic [6:0] div_step_q; // divider iteration count
	logic [15:0] pg_cnt_q; // pulse-train phase counter
	logic pg_out_q; // pulse-train level

	logic setup_ph, wr_en, addr_ok, int_tb, tb_tick, us_tick;
	logic gate_rise, gate_fall, start, abort, tc_hit, limit_hit;
	logic [31:0] tc_val, limit_us, tb_hz, rd_data, cnt_d;
	logic [2:0] ev;
	logic [63:0] rem_sh;

	// apb decode: zero-wait slave, unmapped offsets raise pslverr
	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	always_comb begin
		addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:8] == 24'h0);
		// only the listed word offsets exist
		unique case (paddr[7:0])
			PWPC_CTRL_OFS, PWPC_CMD_OFS, PWPC_TBASE_OFS, PWPC_LIMIT_OFS, PWPC_COUNT_OFS,
			PWPC_TIME_OFS, PWPC_STAT_OFS, PWPC_ISTAT_OFS, PWPC_ICLR_OFS, PWPC_IEN_OFS,
			PWPC_PGEN_OFS: ;
			default: addr_ok = 1'b0;
		endcase
	end
	assign start = wr_en && paddr[7:0] == PWPC_CMD_OFS && pwdata[PWPC_CMD_START_BIT];
	assign abort = wr_en && paddr[7:0] == PWPC_CMD_OFS && pwdata[PWPC_CMD_ABORT_BIT];

	// read mux; write-only registers read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr[7:0])
			PWPC_CTRL_OFS: rd_data = {28'h0, ctrl_q};
			PWPC_TBASE_OFS: rd_data = tbase_q;
			PWPC_LIMIT_OFS: rd_data = limit_q;
			PWPC_COUNT_OFS: rd_data = cnt_q;
			PWPC_TIME_OFS: rd_data = time_q;
			PWPC_STAT_OFS: rd_data = {27'h0, state_q != PWPC_IDLE, res_q};
			PWPC_ISTAT_OFS: rd_data = {29'h0, istat_q};
			PWPC_IEN_OFS: rd_data = {29'h0, ien_q};
			PWPC_PGEN_OFS: rd_data = {16'h0, pgen_q};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			// refused offsets read zero even where the low byte aliases a register
			prdata <= addr_ok ? rd_data : 32'h0000_0000;
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= PWPC_CTRL_RST;
			tbase_q <= PWPC_TBASE_RST;
			limit_q <= PWPC_LIMIT_RST;
			pgen_q <= PWPC_PGEN_RST;
			ien_q <= 3'h0;
		end else if (wr_en) begin
			unique case (paddr[7:0])
				PWPC_CTRL_OFS: ctrl_q <= pwdata[3:0];
				PWPC_TBASE_OFS: tbase_q <= pwdata;
				PWPC_LIMIT_OFS: limit_q <= pwdata;
				PWPC_PGEN_OFS: pgen_q <= pwdata[15:0];
				PWPC_IEN_OFS: ien_q <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// pin synchronisers; a level change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_sync_q <= 3'h0;
			gate_lvl_q <= 1'b0;
			etb_sync_q <= 3'h0;
			etb_lvl_q <= 1'b0;
		end else begin
			gate_sync_q <= {gate_sync_q[1:0], measured_input_pin};
			etb_sync_q <= {etb_sync_q[1:0], ext_timebase_pin};
			if (gate_sync_q[1] == gate_sync_q[2]) begin
				gate_lvl_q <= gate_sync_q[2];
			end
			if (etb_sync_q[1] == etb_sync_q[2]) begin
				etb_lvl_q <= etb_sync_q[2];
			end
		end
	end
	assign gate_rise = gate_sync_q[1] == gate_sync_q[2] && gate_sync_q[2] && !gate_lvl_q;
	assign gate_fall = gate_sync_q[1] == gate_sync_q[2] && !gate_sync_q[2] && gate_lvl_q;

	// timebase select; the internal clock is an enable pulse every fifth pclk
	assign int_tb = tbase_q == 32'h0 || tbase_q == PWPC_INT_TB_HZ;
	assign tb_hz = int_tb ? PWPC_INT_TB_HZ : tbase_q;
	assign tb_tick = int_tb ? (tb_div_q == 3'(PWPC_TB_DIV - 1))
		: (etb_sync_q[1] == etb_sync_q[2] && etb_sync_q[2] && !etb_lvl_q);
	assign us_tick = us_div_q == 6'(PWPC_US_DIV - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_div_q <= 3'h0;
			us_div_q <= 6'h0;
		end else begin
			tb_div_q <= (tb_div_q == 3'(PWPC_TB_DIV - 1)) ? 3'h0 : tb_div_q + 3'h1;
			us_div_q <= us_tick ? 6'h0 : us_div_q + 6'h1;
		end
	end

	// the two 16-bit halves act as one counter when cascaded
	assign tc_val = ctrl_q.cascade ? PWPC_TC_CASCADE : PWPC_TC_SINGLE;
	assign tc_hit = cnt_q == tc_val;
	// default limit waits for both five seconds and four counter ranges
	assign limit_us = (limit_q == PWPC_LIMIT_DEFAULT) ? 32'(DEF_LIMIT_US) : limit_q;
	assign limit_hit = us_cnt_q >= limit_us
		&& (limit_q != PWPC_LIMIT_DEFAULT || rng_cnt_q == PWPC_RANGE_TICKS);
	assign rem_sh = {rem_q[62:0], quo_q[63]};
	// count including a tick in the closing cycle, so flags and time match count
	assign cnt_d = (state_q == PWPC_COUNT && tb_tick && !tc_hit) ? cnt_q + 32'h1 : cnt_q;

	// measurement sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PWPC_IDLE;
		end else if (abort) begin
			state_q <= PWPC_IDLE;
		end else begin
			unique case (state_q)
				PWPC_IDLE: if (start) state_q <= PWPC_ARM;
				// partial interval already running is ignored until its opening edge
				PWPC_ARM: begin
					if (limit_hit) state_q <= PWPC_IDLE;
					else if (open_edge(ctrl_q.mtype, gate_rise, gate_fall)) state_q <= PWPC_COUNT;
				end
				PWPC_COUNT: begin
					if (close_edge(ctrl_q.mtype, gate_rise, gate_fall) || tc_hit) begin
						state_q <= PWPC_DIVIDE;
					end else if (limit_hit) begin
						state_q <= PWPC_IDLE;
					end
				end
				PWPC_DIVIDE: if (div_step_q == 7'(PWPC_DIV_STEPS)) state_q <= PWPC_IDLE;
				// unused state codes fall back to idle
				default: state_q <= PWPC_IDLE;
			endcase
		end
	end

	// tick accumulator and timeout clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			us_cnt_q <= 32'h0;
			rng_cnt_q <= 19'h0;
		end else if (start && state_q == PWPC_IDLE) begin
			cnt_q <= 32'h0;
			us_cnt_q <= 32'h0;
			rng_cnt_q <= 19'h0;
		end else begin
			// counting only inside the gated interval, held at terminal count
			if (state_q == PWPC_COUNT && tb_tick && !tc_hit) begin
				cnt_q <= cnt_q + 32'h1;
			end
			if (us_tick && us_cnt_q != 32'hFFFF_FFFF) begin
				us_cnt_q <= us_cnt_q + 32'h1;
			end
			if (tb_tick && rng_cnt_q != PWPC_RANGE_TICKS) begin
				rng_cnt_q <= rng_cnt_q + 19'h1;
			end
		end
	end

	// result flags; cleared at start so stale flags never mix with a new run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= '0;
		end else if (start && state_q == PWPC_IDLE) begin
			res_q <= '0;
		end else if (state_q == PWPC_COUNT && !abort) begin
			if (close_edge(ctrl_q.mtype, gate_rise, gate_fall) || tc_hit) begin
				res_q.overflow <= tc_hit;
				res_q.underflow <= cnt_d <= PWPC_UDF_THRESH;
				res_q.valid <= !tc_hit && cnt_d > PWPC_UDF_THRESH;
			end else if (limit_hit) begin
				res_q.timeout <= 1'b1;
			end
		end else if (state_q == PWPC_ARM && limit_hit && !abort) begin
			res_q.timeout <= 1'b1;
		end
	end

	// time = count * 1e6 / timebase, restoring division one bit per cycle
	// slow but small; the result lands 65 cycles after the interval closes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_q <= 64'h0;
			quo_q <= 64'h0;
			div_step_q <= 7'h0;
			time_q <= 32'h0;
		end else if (state_q == PWPC_COUNT) begin
			rem_q <= 64'h0;
			quo_q <= 64'(cnt_d) * 64'(PWPC_US_PER_S);
			div_step_q <= 7'h0;
		end else if (state_q == PWPC_DIVIDE) begin
			if (div_step_q == 7'(PWPC_DIV_STEPS)) begin
				time_q <= quo_q[31:0];
			end else begin
				div_step_q <= div_step_q + 7'h1;
				if (rem_sh >= {32'h0, tb_hz}) begin
					rem_q <= rem_sh - {32'h0, tb_hz};
					quo_q <= {quo_q[62:0], 1'b1};
				end else begin
					rem_q <= rem_sh;
					quo_q <= {quo_q[62:0], 1'b0};
				end
			end
		end
	end

	// events: done, overflow, timeout
	assign ev[PWPC_IRQ_DONE_BIT] = state_q == PWPC_DIVIDE && div_step_q == 7'(PWPC_DIV_STEPS);
	assign ev[PWPC_IRQ_OVF_BIT] = state_q == PWPC_COUNT && tc_hit && !abort;
	assign ev[PWPC_IRQ_TMO_BIT] = (state_q == PWPC_ARM
		|| (state_q == PWPC_COUNT && !tc_hit && !close_edge(ctrl_q.mtype, gate_rise, gate_fall)))
		&& limit_hit && !abort;

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= 3'h0;
		end else begin
			istat_q <= (istat_q & ~((wr_en && paddr[7:0] == PWPC_ICLR_OFS) ? pwdata[2:0] : 3'h0)) | ev;
		end
	end
	assign irq = |(istat_q & ien_q);

	// continuous pulse train, half period per phase in timebase ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_cnt_q <= 16'h0;
			pg_out_q <= 1'b0;
		end else if (!ctrl_q.pgen_en) begin
			pg_cnt_q <= 16'h0;
			pg_out_q <= 1'b0;
		end else if (tb_tick) begin
			if (pg_cnt_q + 16'h1 >= pgen_q) begin
				pg_cnt_q <= 16'h0;
				pg_out_q <= !pg_out_q;
			end else begin
				pg_cnt_q <= pg_cnt_q + 16'h1;
			end
		end
	end
	assign counter_output_pin = pg_out_q;
endmodule
`default_nettype wire

/* test/pwpc_assertions.sv */
// checker: bus and output timing properties of the counter
`timescale 1ns/1ps
`default_nettype none
module pwpc_assertions
	import pwpc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic counter_output_pin,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// unmapped word or misaligned byte address
	logic bad;
	assign bad = (paddr > 32'h28) || (paddr[1:0] != 2'h0);
	sequence s_acc;
		psel && penable && !bad;
	endsequence
	sequence s_bad_acc;
		psel && penable && bad;
	endsequence
	// mask cleared: irq must drop whatever status holds
	sequence s_ien_off;
		psel && penable && pwrite && paddr == {24'h0, PWPC_IEN_OFS} && pwdata == 32'h0;
	endsequence
	AST_PREADY: assert property (pready)
		else $error("pready low");
	AST_BAD_ERR: assert property (s_bad_acc |-> pslverr)
		else $error("unmapped access without error");
	AST_GOOD_OK: assert property (s_acc |-> !pslverr)
		else $error("mapped access with error");
	AST_IDLE_OK: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	AST_BAD_RD: assert property (s_bad_acc ##0 !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
		else $error("read data moved");
	AST_IEN_OFF: assert property (s_ien_off |=> !irq [*2])
		else $error("irq high with mask clear");
	AST_OUT_GAP: assert property ($changed(counter_output_pin) |=> $stable(counter_output_pin) [*4])
		else $error("pulse output toggles faster than timebase");
endmodule
bind pwpc_counter pwpc_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .counter_output_pin, .irq);
`default_nettype wire

/* test/pwpc_signal_src.sv */
// partner: square wave on the measured pin and a free external timebase
`timescale 1ns/1ps
`default_nettype none
module pwpc_signal_src (
	input wire logic pclk,
	input wire logic run,
	input wire logic [31:0] hi_c,
	input wire logic [31:0] lo_c,
	output logic measured_input_pin = 1'b0,
	output logic ext_timebase_pin = 1'b0
);
	logic [31:0] n = 32'h0;
	logic [3:0] e = 4'h0;
	// phase lengths in pclk cycles; stopped source idles low
	always_ff @(posedge pclk) begin
		if (!run) begin
			n <= 32'h0;
			measured_input_pin <= 1'b0;
		end else if (n + 1 >= (measured_input_pin ? hi_c : lo_c)) begin
			n <= 32'h0;
			measured_input_pin <= !measured_input_pin;
		end else begin
			n <= n + 1;
		end
	end
	// external clock toggles every 10 pclk, one rising edge per 20
	always_ff @(posedge pclk) begin
		e <= (e == 4'h9) ? 4'h0 : e + 4'h1;
		if (e == 4'h9) begin
			ext_timebase_pin <= !ext_timebase_pin;
		end
	end
endmodule
`default_nettype wire

/* test/pulse_width_period_counter_tb_top.sv */
// testbench: register level tests of the pulse width/period counter
`timescale 1ns/1ps
`default_nettype none
module pulse_width_period_counter_tb_top;
	import pwpc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, run, e;
	logic [31:0] paddr, pwdata, hi_c, lo_c, r, c, t, s, n;
	logic [31:0] prdata;
	logic pready, pslverr, min, etb, cop, irq, w;
	logic [31:0] expc [4] = '{32'd10, 32'd20, 32'd30, 32'd30};
	int failures = 0;
	int checks = 0;
	pwpc_counter #(.DEF_LIMIT_US(200)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .measured_input_pin(min),
		.ext_timebase_pin(etb), .counter_output_pin(cop), .irq(irq));
	pwpc_signal_src u_src (.pclk(pclk), .run(run), .hi_c(hi_c), .lo_c(lo_c),
		.measured_input_pin(min), .ext_timebase_pin(etb));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic complete_run;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; the request stands until pready is seen high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// configure, start, wait for busy to drop, collect results
	task automatic meas(input logic [3:0] ctl, input logic [31:0] h, input logic [31:0] l);
		hi_c <= h;
		lo_c <= l;
		run <= 1'b1;
		xfer(1'b1, PWPC_CTRL_OFS, {28'h0, ctl});
		xfer(1'b1, PWPC_ICLR_OFS, 32'h7);
		xfer(1'b1, PWPC_CMD_OFS, 32'h1);
		do xfer(1'b0, PWPC_STAT_OFS, 32'h0); while (r[4] === 1'b1);
		xfer(1'b0, PWPC_COUNT_OFS, 32'h0);
		c = r;
		xfer(1'b0, PWPC_TIME_OFS, 32'h0);
		t = r;
		xfer(1'b0, PWPC_STAT_OFS, 32'h0);
		s = r & 32'hF;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		complete_run;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		run = 1'b0;
		hi_c = 32'd50;
		lo_c = 32'd100;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, PWPC_CTRL_OFS, 32'h0);
		chk(r, 32'h2);
		xfer(1'b0, PWPC_TBASE_OFS, 32'h0);
		chk(r, 32'h0);
		xfer(1'b0, PWPC_LIMIT_OFS, 32'h0);
		chk(r, 32'hFFFFFFFF);
		xfer(1'b0, PWPC_PGEN_OFS, 32'h0);
		chk(r, 32'h1);
		// unmapped address is refused and reads zero
		xfer(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		// every type: 50 cycles high, 100 low, ticks every 5 cycles
		for (int i = 0; i < 4; i++) begin
			meas(i[3:0], 32'd50, 32'd100);
			chk(c, expc[i]);
			chk(t, expc[i] / 10);
			chk(s, 32'h1);
		end
		// done is sticky but masked
		xfer(1'b0, PWPC_ISTAT_OFS, 32'h0);
		chk(r & 32'h7, 32'h1);
		chk({31'h0, irq}, 32'h0);
		meas(4'h6, 32'd50, 32'd100);
		chk(c, 32'd30);
		xfer(1'b1, PWPC_TBASE_OFS, 32'd10000000);
		meas(4'h2, 32'd50, 32'd100);
		chk(c, 32'd30);
		// external clock: one tick per 20 cycles, 100 cycle period
		xfer(1'b1, PWPC_TBASE_OFS, 32'd1000000);
		meas(4'h2, 32'd50, 32'd50);
		chk(c, 32'd5);
		chk(t, 32'd5);
		xfer(1'b1, PWPC_TBASE_OFS, 32'h0);
		meas(4'h2, 32'd10, 32'd10);
		chk(s, 32'h4);
		// input stuck longer than a 20 us limit
		xfer(1'b1, PWPC_IEN_OFS, 32'h4);
		xfer(1'b1, PWPC_LIMIT_OFS, 32'd20);
		meas(4'h2, 32'd5000, 32'd5000);
		chk(s, 32'h8);
		xfer(1'b0, PWPC_ISTAT_OFS, 32'h0);
		chk(r & 32'h7, 32'h4);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, PWPC_ICLR_OFS, 32'h4);
		#1;
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, PWPC_IEN_OFS, 32'h0);
		xfer(1'b1, PWPC_LIMIT_OFS, 32'hFFFFFFFF);
		// abort while armed: back to idle with no flags
		xfer(1'b1, PWPC_CMD_OFS, 32'h1);
		xfer(1'b1, PWPC_CMD_OFS, 32'h2);
		xfer(1'b0, PWPC_STAT_OFS, 32'h0);
		chk(r & 32'h1F, 32'h0);
		// pulse train: 4 ticks of 5 cycles between toggles, sampled off the edge
		xfer(1'b1, PWPC_PGEN_OFS, 32'h4);
		xfer(1'b1, PWPC_CTRL_OFS, 32'hA);
		w = cop;
		repeat (200) begin
			@(negedge pclk);
			if (cop !== w) break;
		end
		w = cop;
		n = 32'h0;
		repeat (200) begin
			@(negedge pclk);
			n++;
			if (cop !== w) break;
		end
		chk(n, 32'd20);
		xfer(1'b1, PWPC_CTRL_OFS, 32'h2);
		complete_run;
	end
endmodule
`default_nettype wire
